// ---- rtl/lvic_ctrl.sv ----
// level interrupt vector controller with AHB-Lite register slave
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module lvic_ctrl (
    input  wire logic        clk,         // core clock
    input  wire logic        sys_rst,     // synchronous reset
    // ahb-lite slave
    input  wire logic        hsel,        // slave select
    input  wire logic [7:0]  haddr,       // byte address
    input  wire logic [1:0]  htrans,      // transfer type
    input  wire logic        hwrite,      // write
    input  wire logic [2:0]  hsize,       // size
    input  wire logic [31:0] hwdata,      // write data
    input  wire logic        hready,      // bus ready
    output logic [31:0]      hrdata,      // read data
    output logic             hreadyout,   // slave ready
    output logic             hresp,       // always okay
    // sources and core
    input  wire logic [22:0] srcEvent,    // one-cycle source events
    input  wire logic [22:0] srcHwClear,  // hardware clears on service
    input  wire logic        timerOvf,    // basic timer overflow pulse
    input  wire logic        coreAck,     // core takes the grant
    output logic             intReq,      // request to the core
    output logic [7:0]       intVector,   // vector byte address
    output logic [2:0]       intLevel,    // winning level
    output logic             resetVecReq, // reset-class restart
    output logic [15:0]      resetVector  // restart address
);

    // ========================================================
    // register state
    logic [4:0]  mode,    next_mode;    // system mode register
    logic [7:0]  mask,    next_mask;    // level mask register
    logic [7:0]  prio,    next_prio;    // level priority register
    logic [22:0] srcEn,   next_srcEn;   // per-source enables
    logic [22:0] pend,    next_pend;    // latched source requests
    logic        ovfFlag, next_ovfFlag; // timer overflow flag
    lvic_pkg::lvic_grant_t grant, next_grant; // registered grant
    logic [31:0] rdata,   next_rdata;   // read data register

    // ========================================================
    // bus address phase capture
    logic        dpWrite, next_dpWrite; // data phase is a write
    logic        dpRead,  next_dpRead;  // data phase is a read
    logic [7:0]  dpAddr,  next_dpAddr;  // captured address
    logic        addrOk;                // valid address phase

    // zero wait states; reads are captured in the address phase, so
    // hrdata stands for the whole data phase
    assign addrOk    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata;

    // ========================================================
    // arbitration signals
    logic [7:0]  levelReq;   // per-level pending (any source)
    logic [7:0]  levelLive;  // unmasked, enabled levels
    logic [22:0] srcLive;    // pending and enabled sources
    logic        anyLvl;     // some level eligible
    logic [2:0]  winLvl;     // winning level
    logic [4:0]  winSrc;     // winning source index
    logic        winFound;   // a source within level found

    // per-level flags from latched sources
    always_comb begin
        levelReq  = 8'h00;
        levelLive = 8'h00;
        for (int s = 0; s < lvic_pkg::NUM_SRC; s++) begin
            srcLive[s] = pend[s] && srcEn[s];
            if (pend[s]) levelReq[lvic_pkg::SRC_LVL[s]] = 1'b1;
            if (srcLive[s]) levelLive[lvic_pkg::SRC_LVL[s]] = 1'b1;
        end
        levelLive = levelLive & mask;
    end

    // level priority resolution
    lvic_level_rank lvic_level_rank_i (
        .prio   (prio),
        .active (levelLive),
        .any    (anyLvl),
        .level  (winLvl)
    );

    // source choice inside the winning level
    always_comb begin
        winSrc   = 5'h00;
        winFound = 1'b0;
        for (int s = lvic_pkg::NUM_SRC - 1; s >= 0; s--) begin
            if (srcLive[s] && lvic_pkg::SRC_LVL[s] == winLvl) begin
                winSrc   = 5'(s);
                winFound = 1'b1;
            end
        end
    end

    // ========================================================
    // next-state logic for registers, pending and grant
    always_comb begin
        next_mode    = mode;
        next_mask    = mask;
        next_prio    = prio;
        next_srcEn   = srcEn;
        next_pend    = pend;
        next_ovfFlag = 1'b0;
        next_grant   = grant;
        next_rdata   = rdata;
        next_dpWrite = addrOk && hwrite;
        next_dpRead  = addrOk && !hwrite;
        next_dpAddr  = addrOk ? haddr : dpAddr;
        // read data for the data phase
        if (addrOk && !hwrite) begin
            case (haddr)
                lvic_pkg::OFF_MODE:  next_rdata = {27'h0, mode};
                lvic_pkg::OFF_MASK:  next_rdata = {24'h0, mask};
                lvic_pkg::OFF_PRIO:  next_rdata = {24'h0, prio};
                lvic_pkg::OFF_REQ:   next_rdata = {24'h0, levelReq};
                lvic_pkg::OFF_SRCEN: next_rdata = {9'h0, srcEn};
                lvic_pkg::OFF_PEND:  next_rdata = {9'h0, pend};
                lvic_pkg::OFF_VEC:   next_rdata = {15'h0, grant};
                // unmapped offsets read as zero
                default:             next_rdata = 32'h0000_0000;
            endcase
        end
        // register writes in the data phase
        if (dpWrite) begin
            case (dpAddr)
                lvic_pkg::OFF_MODE:  next_mode  = hwdata[4:0];
                lvic_pkg::OFF_MASK:  next_mask  = hwdata[7:0];
                lvic_pkg::OFF_PRIO:  next_prio  = hwdata[7:0];
                lvic_pkg::OFF_SRCEN: next_srcEn = hwdata[22:0];
                lvic_pkg::OFF_PEND:  next_pend  = pend & ~hwdata[22:0];
                lvic_pkg::OFF_CMD: begin
                    if (hwdata[lvic_pkg::CMD_ON])
                        next_mode[lvic_pkg::MODE_GIE] = 1'b1;
                    else if (hwdata[lvic_pkg::CMD_OFF])
                        next_mode[lvic_pkg::MODE_GIE] = 1'b0;
                end
                // read-only and unmapped offsets ignore writes
                default: ;
            endcase
        end
        // hardware clear on service
        next_pend = next_pend & ~srcHwClear;
        // new events latch; set beats clear
        next_pend = next_pend | srcEvent;
        next_grant.valid = mode[lvic_pkg::MODE_GIE] && anyLvl && winFound;
        next_grant.level = winLvl;
        next_grant.src   = winSrc;
        // vector from fixed table, below 256
        next_grant.vec   = lvic_pkg::SRC_VEC[winSrc];
        // the acknowledge wins over a same-cycle enable strobe
        // grant disables further interrupts
        if (coreAck && grant.valid) begin
            next_mode[lvic_pkg::MODE_GIE] = 1'b0;
            next_grant.valid              = 1'b0;
        end
        // timer overflow is a reset-class event
        if (timerOvf) next_ovfFlag = 1'b1;
    end

    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // mode bits 0 and 1 cleared
            mode    <= lvic_pkg::MODE_RESET;
            mask    <= lvic_pkg::MASK_RESET;
            prio    <= lvic_pkg::PRIO_RESET;
            srcEn   <= 23'h000000;
            pend    <= 23'h000000;
            ovfFlag <= 1'b0;
            grant   <= '0;
            rdata   <= 32'h0000_0000;
            dpWrite <= 1'b0;
            dpRead  <= 1'b0;
            dpAddr  <= 8'h00;
        end else begin
            mode    <= next_mode;
            mask    <= next_mask;
            prio    <= next_prio;
            srcEn   <= next_srcEn;
            pend    <= next_pend;
            ovfFlag <= next_ovfFlag;
            grant   <= next_grant;
            rdata   <= next_rdata;
            dpWrite <= next_dpWrite;
            dpRead  <= next_dpRead;
            dpAddr  <= next_dpAddr;
        end
    end

    // ========================================================
    // outputs to the core
    assign intReq      = grant.valid;
    assign intVector   = grant.vec;
    assign intLevel    = grant.level;
    assign resetVecReq = ovfFlag;
    assign resetVector = lvic_pkg::RESET_VECTOR;

    // ========================================================
    // assertions
    // a vector byte never leaves the low area
    a_vec_area: assert property (@(posedge clk) disable iff (sys_rst)
        intReq |-> {1'b0, intVector} < lvic_pkg::VEC_AREA)
        else $error("vector outside low area");
    // one restart pulse per overflow, never stretched
    a_ovf_restart: assert property (@(posedge clk) disable iff (sys_rst)
        timerOvf |=> resetVecReq ##1 (!resetVecReq || $past(timerOvf)))
        else $error("overflow restart wrong");
    // level 3 picks its live source with the lowest vector
    a_in_level: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(intReq) |-> intVector == lvic_pkg::SRC_VEC[intLevel == 3'h3
            ? ($past(srcLive[7]) ? 7 : $past(srcLive[8]) ? 8 : 9)
            : $past(winSrc)])
        else $error("in-level order wrong");
    // nothing is presented unless the global enable was on when it was chosen
    a_gie_gate: assert property (@(posedge clk) disable iff (sys_rst)
        intReq |-> $past(mode[lvic_pkg::MODE_GIE]))
        else $error("request while disabled");
    // the presented level was unmasked when it was chosen
    a_mask_gate: assert property (@(posedge clk) disable iff (sys_rst)
        intReq |-> $past(mask[winLvl]) && $past(levelLive[winLvl]))
        else $error("masked level presented");
    // the acknowledge drops the grant and the global enable
    a_ack_disable: assert property (@(posedge clk) disable iff (sys_rst)
        coreAck && intReq |=> !mode[lvic_pkg::MODE_GIE] && !intReq)
        else $error("grant did not disable");
    // an event of source 0 is never lost
    a_pend_hold: assert property (@(posedge clk) disable iff (sys_rst)
        srcEvent[0] |=> pend[0])
        else $error("source request lost");
    // the watch timer source shows as its level flag
    a_req_flag: assert property (@(posedge clk) disable iff (sys_rst)
        pend[10] |-> levelReq[4])
        else $error("level flag missing");
    // the enable strobe sets bit 0 unless a grant is taken
    a_on_cmd: assert property (@(posedge clk) disable iff (sys_rst)
        dpWrite && dpAddr == lvic_pkg::OFF_CMD && hwdata[lvic_pkg::CMD_ON]
        && !coreAck |=> mode[lvic_pkg::MODE_GIE])
        else $error("enable strobe ignored");
    // reset clears both enables and every level flag
    a_rst_clear: assert property (@(posedge clk)
        sys_rst |=> mode[1:0] == 2'h0 && levelReq == 8'h00)
        else $error("reset values wrong");
    // a request poll returns the flags of the address cycle
    a_req_poll: assert property (@(posedge clk) disable iff (sys_rst)
        dpRead && dpAddr == lvic_pkg::OFF_REQ
        |-> hrdata == {24'h0, $past(levelReq)})
        else $error("request poll wrong");
    // a presented source was enabled and pending when chosen
    a_src_gate: assert property (@(posedge clk) disable iff (sys_rst)
        intReq |-> $past(srcEn[winSrc]) && $past(pend[winSrc]))
        else $error("disabled source presented");
    // pin sources of level 5 use only their fixed vectors
    a_lvl5_vec: assert property (@(posedge clk) disable iff (sys_rst)
        intReq && intLevel == 3'h5
        |-> intVector inside {8'hD8, 8'hDA, 8'hDC, 8'hDE})
        else $error("level 5 vector wrong");
    // serial sources of level 3 use only their fixed vectors
    a_lvl3_vec: assert property (@(posedge clk) disable iff (sys_rst)
        intReq && intLevel == 3'h3
        |-> intVector inside {8'hD0, 8'hD2, 8'hD4})
        else $error("level 3 vector wrong");

    c_grant:   cover property (@(posedge clk) $rose(intReq));
    c_ack:     cover property (@(posedge clk) coreAck && intReq);
    c_restart: cover property (@(posedge clk) resetVecReq);
    c_lvl5:    cover property (@(posedge clk) intReq && intLevel == 3'h5);
    c_prio:    cover property (@(posedge clk) intReq && prio != 8'h00);

endmodule

// ---- rtl/lvic_pkg.sv ----
// package with offsets, field positions, vectors and types of the controller
package lvic_pkg;

    // ========================================================
    // register byte offsets on the AHB-Lite bus
    localparam logic [7:0] OFF_MODE  = 8'h00; // system mode register
    localparam logic [7:0] OFF_MASK  = 8'h04; // level mask register
    localparam logic [7:0] OFF_PRIO  = 8'h08; // level priority register
    localparam logic [7:0] OFF_REQ   = 8'h0C; // level request register (ro)
    localparam logic [7:0] OFF_SRCEN = 8'h10; // per-source enables
    localparam logic [7:0] OFF_PEND  = 8'h14; // source pending, w1 clears
    localparam logic [7:0] OFF_CMD   = 8'h18; // instruction strobes (wo)
    localparam logic [7:0] OFF_VEC   = 8'h1C; // granted vector (ro)

    // ========================================================
    // field positions
    localparam int MODE_GIE    = 0;  // global interrupt enable
    localparam int MODE_FIE    = 1;  // fast interrupt enable
    localparam int MODE_FLV_LO = 2;  // fast level field low bit
    localparam int CMD_ON      = 0;  // enable instruction strobe
    localparam int CMD_OFF     = 1;  // disable instruction strobe
    localparam int PRIO_AB     = 7;  // group order bit a
    localparam int PRIO_SUBC   = 6;  // subgroup c bit
    localparam int PRIO_GRPC   = 5;  // group c bit
    localparam int PRIO_BC     = 4;  // group order bit b
    localparam int PRIO_GRPB   = 3;  // group b bit
    localparam int PRIO_SUBB   = 2;  // subgroup b bit
    localparam int PRIO_CA     = 1;  // group order bit c
    localparam int PRIO_GRPA   = 0;  // group a bit

    // ========================================================
    // sizes, reset values, vectors
    localparam int NUM_LEVELS  = 8;   // request levels 0 to 7
    localparam int NUM_SRC     = 23;  // maskable sources
    localparam logic [15:0] RESET_VECTOR = 16'h0100; // start address
    localparam logic [8:0]  VEC_AREA     = 9'h100;   // vectors below this
    localparam logic [4:0]  MODE_RESET   = 5'h00;    // flv field unspec
    localparam logic [7:0]  MASK_RESET   = 8'h00;    // undefined; zero
    localparam logic [7:0]  PRIO_RESET   = 8'h00;    // undefined; zero

    // source table ordered so index within a level rises with vector
    localparam logic [7:0] SRC_VEC [NUM_SRC] = '{
        8'hE0, 8'hE2,                 // level 0
        8'hE4, 8'hE6,                 // level 1
        8'hE8, 8'hEA, 8'hEC,          // level 2
        8'hD0, 8'hD2, 8'hD4,          // level 3
        8'hD6,                        // level 4
        8'hD8, 8'hDA, 8'hDC, 8'hDE,   // level 5
        8'hC0, 8'hC2, 8'hC4, 8'hC6,   // level 6
        8'hC8, 8'hCA, 8'hCC, 8'hCE    // level 7
    };
    localparam logic [2:0] SRC_LVL [NUM_SRC] = '{
        3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3,
        3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6, 3'h6,
        3'h7, 3'h7, 3'h7, 3'h7
    };

    // grant presented to the core
    typedef struct packed {
        logic        valid; // a request is presented
        logic [2:0]  level; // winning level
        logic [4:0]  src;   // winning source index
        logic [7:0]  vec;   // vector byte address
    } lvic_grant_t;

endpackage

// ---- rtl/lvic_level_rank.sv ----
// picks the winning level from the priority register
`timescale 1ns/1ps
module lvic_level_rank (
    input  wire logic [7:0] prio,   // level priority register
    input  wire logic [7:0] active, // levels with a live request
    output logic            any,    // some level active
    output logic [2:0]      level   // winning level
);

    // ========================================================
    // ordered list of levels, best first
    logic [2:0] order [8];
    logic [2:0] grpA [2];
    logic [2:0] grpB [3];
    logic [2:0] grpC [3];
    logic [2:0] gsel;

    // builds the group contents and order, then scans it
    always_comb begin
        // group a: bit 0 swaps levels 0 and 1
        grpA[0] = prio[lvic_pkg::PRIO_GRPA] ? 3'h1 : 3'h0;
        grpA[1] = prio[lvic_pkg::PRIO_GRPA] ? 3'h0 : 3'h1;
        // group b: level 2 vs subgroup 3/4
        if (prio[lvic_pkg::PRIO_GRPB]) begin
            grpB[0] = prio[lvic_pkg::PRIO_SUBB] ? 3'h4 : 3'h3;
            grpB[1] = prio[lvic_pkg::PRIO_SUBB] ? 3'h3 : 3'h4;
            grpB[2] = 3'h2;
        end else begin
            grpB[0] = 3'h2;
            grpB[1] = prio[lvic_pkg::PRIO_SUBB] ? 3'h4 : 3'h3;
            grpB[2] = prio[lvic_pkg::PRIO_SUBB] ? 3'h3 : 3'h4;
        end
        // group c: level 5 vs subgroup 6/7
        if (prio[lvic_pkg::PRIO_GRPC]) begin
            grpC[0] = prio[lvic_pkg::PRIO_SUBC] ? 3'h7 : 3'h6;
            grpC[1] = prio[lvic_pkg::PRIO_SUBC] ? 3'h6 : 3'h7;
            grpC[2] = 3'h5;
        end else begin
            grpC[0] = 3'h5;
            grpC[1] = prio[lvic_pkg::PRIO_SUBC] ? 3'h7 : 3'h6;
            grpC[2] = prio[lvic_pkg::PRIO_SUBC] ? 3'h6 : 3'h7;
        end
        gsel = {prio[lvic_pkg::PRIO_AB], prio[lvic_pkg::PRIO_BC],
                prio[lvic_pkg::PRIO_CA]};
        // group order; 001 gives B>C>A, 101 gives C>B>A
        case (gsel)
            3'h1: order = '{grpB[0], grpB[1], grpB[2], grpC[0],
                            grpC[1], grpC[2], grpA[0], grpA[1]};
            3'h2: order = '{grpA[0], grpA[1], grpB[0], grpB[1],
                            grpB[2], grpC[0], grpC[1], grpC[2]};
            3'h3: order = '{grpB[0], grpB[1], grpB[2], grpA[0],
                            grpA[1], grpC[0], grpC[1], grpC[2]};
            3'h4: order = '{grpC[0], grpC[1], grpC[2], grpA[0],
                            grpA[1], grpB[0], grpB[1], grpB[2]};
            3'h5: order = '{grpC[0], grpC[1], grpC[2], grpB[0],
                            grpB[1], grpB[2], grpA[0], grpA[1]};
            3'h6: order = '{grpA[0], grpA[1], grpC[0], grpC[1],
                            grpC[2], grpB[0], grpB[1], grpB[2]};
            default: order = '{grpA[0], grpA[1], grpB[0], grpB[1],
                            grpB[2], grpC[0], grpC[1], grpC[2]};
        endcase
        // scan from worst to best so the best active wins
        any   = 1'b0;
        level = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (active[order[i]]) begin
                any   = 1'b1;
                level = order[i];
            end
        end
    end

endmodule

// ---- verification/lvic_core_model.sv ----
// processor core model that takes grants and fetches service vectors
`timescale 1ns/1ps
module lvic_core_model (
    input  wire logic        clk,       // core clock
    input  wire logic        sysRst,    // synchronous reset
    input  wire logic        intReq,    // grant from the controller
    input  wire logic [7:0]  intVector, // vector byte address
    input  wire logic [2:0]  intLevel,  // winning level
    input  wire logic        ackEn,     // core accepts grants at all
    input  wire logic [3:0]  ackDly,    // cycles before accepting
    output logic             coreAck,   // one-cycle accept pulse
    output logic [15:0]      fetchAddr, // first vector byte fetched
    output logic [2:0]       gotLevel,  // level of the last grant
    output logic [7:0]       acks       // grants taken so far
);
    // ========================================
    // acceptance state
    logic [3:0] waitCnt; // cycles the grant has stood
    logic       busy;    // accepted, waiting for the grant to drop

    // accept after ackDly cycles, then hold off until the grant drops,
    // so one grant is never taken twice
    always @(posedge clk) begin
        coreAck <= !sysRst && !busy && intReq && ackEn && waitCnt == ackDly;
        if (sysRst) begin
            waitCnt   <= 4'h0;
            busy      <= 1'b0;
            acks      <= 8'h00;
            fetchAddr <= 16'h0000;
            gotLevel  <= 3'h0;
        end else if (busy) begin
            busy <= intReq;
        end else if (intReq && ackEn) begin
            if (waitCnt == ackDly) begin
                busy      <= 1'b1;
                waitCnt   <= 4'h0;
                fetchAddr <= {8'h00, intVector};
                gotLevel  <= intLevel;
                acks      <= acks + 8'h01;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end else begin
            waitCnt <= 4'h0;
        end
    end
endmodule

// ---- verification/lvic_ctrl_tb_top.sv ----
// self-checking bench for the level interrupt vector controller
`timescale 1ns/1ps
module lvic_ctrl_tb_top;
    // ========================================
    // stimulus, observed outputs and counters
    logic        clk = 1'b0;       // core clock
    logic        sysRst = 1'b1;    // synchronous reset
    logic [7:0]  haddr = 8'h00;    // bus address
    logic [1:0]  htrans = 2'h0;    // transfer type
    logic        hwrite = 1'b0;    // write flag
    logic [31:0] hwdata = 32'h0;   // write data
    logic [31:0] hrdata;           // read data
    logic        hreadyout;        // slave ready, also bus ready
    logic        hresp;            // response
    logic [22:0] srcEvent = '0;    // source events
    logic [22:0] srcHwClear = '0;  // hardware clears
    logic        timerOvf = 1'b0;  // timer overflow pulse
    logic        ackEn = 1'b0;     // core accepts grants
    logic [3:0]  ackDly = 4'h0;    // core acceptance delay
    logic        coreAck, intReq, resetVecReq;
    logic [7:0]  intVector, acks;
    logic [2:0]  intLevel, gotLevel;
    logic [15:0] resetVector, fetchAddr;
    logic [31:0] rdq;              // last read word
    int          errors = 0;       // mismatches
    int          samplesChecked = 0; // comparisons
    // per source index: vector and level it must give
    logic [7:0] rowVec [23] = '{8'hE0, 8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA,
        8'hEC, 8'hD0, 8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hDA, 8'hDC, 8'hDE,
        8'hC0, 8'hC2, 8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hCE};
    logic [2:0] rowLvl [23] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6, 3'h6,
        3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    // priority settings and the winner among levels 0, 1, 3 and 5
    logic [7:0] prRow [9] = '{8'h00, 8'h01, 8'h02, 8'h82, 8'h10, 8'h12,
        8'h80, 8'h90, 8'h92};
    logic [7:0] prVec [9] = '{8'hE0, 8'hE4, 8'hD0, 8'hD8, 8'hE0, 8'hD0,
        8'hD8, 8'hE0, 8'hE0};

    always #2 clk = ~clk;

    // ========================================
    // controller and core model
    lvic_ctrl lvic_ctrl_i (.clk(clk), .sys_rst(sysRst), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .srcEvent(srcEvent),
        .srcHwClear(srcHwClear), .timerOvf(timerOvf), .coreAck(coreAck),
        .intReq(intReq), .intVector(intVector), .intLevel(intLevel),
        .resetVecReq(resetVecReq), .resetVector(resetVector));
    lvic_core_model lvic_core_model_i (.clk(clk), .sysRst(sysRst),
        .intReq(intReq), .intVector(intVector), .intLevel(intLevel),
        .ackEn(ackEn), .ackDly(ackDly), .coreAck(coreAck),
        .fetchAddr(fetchAddr), .gotLevel(gotLevel), .acks(acks));

    // ========================================
    // helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one single word transfer, waiting on ready in both phases
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdq = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdq, e);
        chk({hreadyout, hresp}, 2'h2);
    endtask
    // one-cycle event pulse, then a gap edge
    task ev(input logic [22:0] m);
        srcEvent <= m;
        @(posedge clk);
        srcEvent <= '0;
        @(posedge clk);
    endtask
    // fire sources lo..hi together, then clear them lowest first
    task chain(input int lo, input int hi);
        int j;
        ev((23'h1 << (hi + 1)) - (23'h1 << lo));
        for (j = lo; j <= hi; j++) begin
            repeat (2) @(posedge clk);
            chk(intVector, rowVec[j]);
            bus(1'b1, lvic_pkg::OFF_PEND, 32'h1 << j);
        end
        repeat (2) @(posedge clk);
        chk(intReq, 1'b0);
    endtask
    task tally_and_finish;
        $display("errors %0d checked %0d", errors, samplesChecked);
        if (errors == 0 && samplesChecked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish;
    end

    // ========================================
    // main sequence
    initial begin
        int i;
        int k;
        logic [7:0] n;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        rd(lvic_pkg::OFF_MODE, 32'h0);
        rd(lvic_pkg::OFF_REQ, 32'h0);
        chk(intReq, 1'b0);
        bus(1'b1, lvic_pkg::OFF_MASK, 32'hFF);
        rd(lvic_pkg::OFF_MASK, 32'hFF);
        bus(1'b1, lvic_pkg::OFF_SRCEN, 32'h7FFFFF);
        ackEn <= 1'b1;
        // each source alone: vector, level, enable cleared on grant
        for (i = 0; i < 23; i++) begin
            ackDly <= i[0] ? 4'h5 : 4'h0;
            n = acks;
            bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
            ev(23'h1 << i);
            k = 0;
            while (acks == n && k < 40) begin
                @(posedge clk);
                k++;
            end
            chk(fetchAddr, {8'h00, rowVec[i]});
            chk(gotLevel, rowLvl[i]);
            rd(lvic_pkg::OFF_MODE, 32'h0);
            bus(1'b1, lvic_pkg::OFF_PEND, 32'h1 << i);
            rd(lvic_pkg::OFF_REQ, 32'h0);
        end
        ackEn <= 1'b0;
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
        chain(11, 14);
        chain(7, 9);
        // priority among levels through every group order
        ev(23'h000885);
        for (i = 0; i < 9; i++) begin
            bus(1'b1, lvic_pkg::OFF_PRIO, {24'h0, prRow[i]});
            repeat (2) @(posedge clk);
            chk(intVector, prVec[i]);
        end
        rd(lvic_pkg::OFF_PRIO, 32'h92);
        bus(1'b1, lvic_pkg::OFF_PEND, 32'h7FFFFF);
        // gating by global enable, mask and source enable
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h2);
        ev(23'h000400);
        repeat (2) @(posedge clk);
        chk(intReq, 1'b0);
        rd(lvic_pkg::OFF_REQ, 32'h10);
        bus(1'b1, lvic_pkg::OFF_MODE, 32'h3);
        repeat (2) @(posedge clk);
        chk(intVector, 8'hD6);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h2);
        rd(lvic_pkg::OFF_MODE, 32'h2);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
        rd(lvic_pkg::OFF_MODE, 32'h3);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h2);
        bus(1'b1, lvic_pkg::OFF_MASK, 32'hEF);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
        repeat (2) @(posedge clk);
        chk(intReq, 1'b0);
        rd(lvic_pkg::OFF_PEND, 32'h400);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h2);
        bus(1'b1, lvic_pkg::OFF_MASK, 32'hFF);
        bus(1'b1, lvic_pkg::OFF_SRCEN, 32'h7FFBFF);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
        repeat (2) @(posedge clk);
        chk(intReq, 1'b0);
        bus(1'b1, lvic_pkg::OFF_SRCEN, 32'h7FFFFF);
        repeat (2) @(posedge clk);
        chk(intReq, 1'b1);
        bus(1'b1, lvic_pkg::OFF_REQ, 32'h0);
        rd(lvic_pkg::OFF_REQ, 32'h10);
        rd(8'h20, 32'h0);
        srcHwClear <= 23'h000400;
        @(posedge clk);
        srcHwClear <= '0;
        @(posedge clk);
        rd(lvic_pkg::OFF_PEND, 32'h0);
        // timer overflow restarts at the reset address
        timerOvf <= 1'b1;
        @(posedge clk);
        timerOvf <= 1'b0;
        #1 chk(resetVecReq, 1'b1);
        chk(resetVector, 32'h100);
        @(posedge clk);
        #1 chk(resetVecReq, 1'b0);
        // reset in mid-run with a live grant
        @(posedge clk);
        bus(1'b1, lvic_pkg::OFF_CMD, 32'h1);
        ev(23'h000001);
        repeat (2) @(posedge clk);
        chk(intReq, 1'b1);
        sysRst <= 1'b1;
        repeat (2) @(posedge clk);
        sysRst <= 1'b0;
        rd(lvic_pkg::OFF_MODE, 32'h0);
        rd(lvic_pkg::OFF_REQ, 32'h0);
        chk(intReq, 1'b0);
        tally_and_finish;
    end
endmodule
